// *** src/fsp_pkg.sv ***
// ==========================================
// Constants for the flash status/power command block
package fsp_pkg;
    // ==========================================
    // Opcodes
    localparam logic [7:0] OPC_READ_STATUS = 8'h05; // read_status_cmd
    localparam logic [7:0] OPC_READ_CONFIG = 8'h35; // read_config_cmd
    localparam logic [7:0] OPC_WRITE_REGS = 8'h01; // write_regs_cmd
    localparam logic [7:0] OPC_SET_LATCH = 8'h06; // set_write_latch_cmd
    localparam logic [7:0] OPC_CLR_LATCH = 8'h04; // clear_write_latch_cmd
    localparam logic [7:0] OPC_LOCKDOWN = 8'h8D; // protect_lockdown_cmd
    localparam logic [7:0] OPC_POWER_DOWN = 8'hB9; // power_down_cmd
    localparam logic [7:0] OPC_POWER_UP = 8'hAB; // power_up_id_cmd
    // ==========================================
    // Status and config field layout
    localparam int SR_BUSY = 0; // Busy flag
    localparam int SR_WEL = 1; // Write enable latch
    localparam int SR_BP_LO = 2; // block_protect_bit0..3 at 2..5
    localparam int CR_VLP = 3; // volatile_lock_flag
    localparam logic [7:0] CR_WR_MASK = 8'hF7; // Config bits a write may change
    localparam logic [3:0] BP_RST = 4'h0; // Protect bits after reset
    localparam logic [7:0] CR_RST = 8'h00; // Config after reset
    // ==========================================
    // APB map
    localparam int ADDR_W = 8; // Decoded address bits
    localparam logic [7:0] ADDR_CTRL = 8'h00; // quad mode, engine busy
    localparam logic [7:0] ADDR_STATE = 8'h04; // Live status view
    localparam int CTRL_QUAD = 0; // quad_line_mode
    localparam int CTRL_BUSY = 1; // Internal write in progress
    localparam int ST_LOWPWR = 16; // Low-power state bit
    localparam int ST_WAKING = 17; // Recovering from power-down
    // ==========================================
    // Timing
    localparam int CLK_PS = 4000; // pclk period
    localparam int PD_ENTRY_NS = 3; // power_down_entry_time, in us
    localparam int STANDBY_NS = 10; // Release to standby, in us
    localparam int SYNC_LAT = 3; // Pin synchroniser delay
    localparam int PD_ENTRY_CYC = (PD_ENTRY_NS * 1000000) / CLK_PS - SYNC_LAT;
    localparam int STANDBY_CYC = (STANDBY_NS * 1000000) / CLK_PS - SYNC_LAT;
    localparam int TMR_W = 12; // Timer width
endpackage : fsp_pkg

// *** src/fsp_core.sv ***
// Contract
// RULE1: 05H returns status, 35H returns config
// RULE2: Status read answered even while busy
// RULE3: Host polls busy before next command
// RULE4: Quad read has one dummy; single none
// RULE5: Read data driven on falling clock edges
// RULE6: Output repeats until chip enable rises
// RULE7: 01H followed by one or two bytes
// RULE8: First byte status, second byte config
// RULE9: 06H sets write enable latch
// RULE10: Host sets latch before every write
// RULE11: 04H clears write enable latch
// RULE12: Latch clear ignored while write runs
// RULE13: 8DH freezes the four protect bits
// RULE14: Lock-down sets volatile lock flag
// RULE15: Lock clears only on hardware reset
// RULE16: B9H enters power-down after frame end
// RULE17: Power-down ignored while device busy
// RULE18: In power-down only release is obeyed
// RULE19: Low-power reached within 3 us
// RULE20: ABH exits; ready within 10 us
// RULE21: Release plus three dummies outputs ID
// RULE22: Host frames each command cleanly
// RULE23: Writes and lock need latch set
`timescale 1ns/10ps
module fsp_core
    import fsp_pkg::*;
#(
    parameter logic [7:0] DEV_ID = 8'h5A // Arbitrary identifier value
) (
    input wire logic pclk, // Clock, 250 MHz
    input wire logic presetn, // Async reset, low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [ADDR_W-1:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic ce_n, // Chip enable pin, low
    input wire logic sck, // Serial clock pin
    input wire logic [3:0] sio_in, // Data pins in
    output logic [3:0] sio_out, // Data pins out
    output logic [3:0] sio_oe, // Data pin enables
    output logic low_power // Deep power-down reached
);
    // ==========================================
    // Types and state
    typedef enum logic [2:0] {FR_IDLE, FR_OPC, FR_DUMMY, FR_DATA, FR_OUT, FR_SKIP} fsp_fr_t;
    typedef enum logic [1:0] {PW_ON, PW_ENTER, PW_DOWN, PW_WAKE} fsp_pw_t;
    fsp_fr_t fr_q; // Frame state
    fsp_pw_t pw_q; // Power state
    logic [1:0] ce_sy_q, sck_sy_q; // Synchronisers
    logic ce_d1_q, sck_d1_q; // Edge history
    logic [3:0] sio_s1_q, sio_s2_q; // Data synchroniser
    logic [7:0] sh_q; // Input shifter
    logic [2:0] cnt_q; // Rise count in byte
    logic [1:0] dcnt_q; // Dummy bytes seen
    logic [1:0] nbyte_q; // Data bytes seen
    logic [7:0] opc_q; // Latched opcode
    logic have_opc_q; // Opcode complete
    logic [7:0] sr_new_q, cr_new_q; // Write payload
    logic [1:0] osel_q; // Output source
    logic [7:0] ob_q; // Output shifter
    logic [2:0] ocnt_q; // Fall count in byte
    logic wel_q; // Write enable latch
    logic [3:0] bp_q; // Protect bits
    logic [7:0] cr_q; // Config register
    logic [1:0] ctrl_q; // quad, busy
    logic [TMR_W-1:0] tmr_q; // Power timer
    logic ce_fall, ce_rise, sck_rise, sck_fall; // Edges
    logic quad, busy, last, lock; // Shorthands
    logic [7:0] byte_in, sr_live, live; // Data views
    logic commit, pw_ok; // Frame end and full-power decode

    assign quad = ctrl_q[CTRL_QUAD];
    assign busy = ctrl_q[CTRL_BUSY];
    assign lock = cr_q[CR_VLP];
    assign ce_fall = ce_d1_q & ~ce_sy_q[1];
    assign ce_rise = ~ce_d1_q & ce_sy_q[1];
    assign sck_rise = ~sck_d1_q & sck_sy_q[1] & ~ce_sy_q[1];
    assign sck_fall = sck_d1_q & ~sck_sy_q[1] & ~ce_sy_q[1];
    assign last = quad ? (cnt_q == 3'd1) : (cnt_q == 3'd7);
    assign byte_in = quad ? {sh_q[3:0], sio_s2_q} : {sh_q[6:0], sio_s2_q[0]};
    assign sr_live = {2'b00, bp_q, wel_q, busy};
    assign commit = ce_rise & have_opc_q;
    assign pw_ok = (pw_q == PW_ON);

    // Read source; live so a status poll sees busy drop
    always_comb begin
        case (osel_q)
            2'd0: live = sr_live; // RULE1
            2'd1: live = cr_q; // RULE1
            default: live = DEV_ID; // RULE21
        endcase
    end

    // ==========================================
    // Pin synchronisers
    // Every pin passes two flops before any decode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ce_sy_q <= 2'b11;
            ce_d1_q <= 1'b1;
            sck_sy_q <= 2'b00;
            sck_d1_q <= 1'b0;
            sio_s1_q <= 4'h0;
            sio_s2_q <= 4'h0;
        end else begin
            ce_sy_q <= {ce_sy_q[0], ce_n};
            ce_d1_q <= ce_sy_q[1];
            sck_sy_q <= {sck_sy_q[0], sck};
            sck_d1_q <= sck_sy_q[1];
            sio_s1_q <= sio_in;
            sio_s2_q <= sio_s1_q;
        end
    end

    // ==========================================
    // Frame decoder
    // Shifts opcode, dummies and payload on rising edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fr_q <= FR_IDLE;
            sh_q <= 8'h00;
            cnt_q <= 3'd0;
            dcnt_q <= 2'd0;
            nbyte_q <= 2'd0;
            opc_q <= 8'h00;
            have_opc_q <= 1'b0;
            sr_new_q <= 8'h00;
            cr_new_q <= 8'h00;
            osel_q <= 2'd0;
        end else if (ce_fall) begin
            fr_q <= FR_OPC;
            cnt_q <= 3'd0;
            dcnt_q <= 2'd0;
            nbyte_q <= 2'd0;
            have_opc_q <= 1'b0;
        end else if (ce_rise) begin
            fr_q <= FR_IDLE; // RULE6
            have_opc_q <= 1'b0;
        end else if (sck_rise && (fr_q == FR_OPC || fr_q == FR_DUMMY || fr_q == FR_DATA)) begin
            sh_q <= byte_in;
            cnt_q <= last ? 3'd0 : cnt_q + 3'd1;
            if (last) begin
                case (fr_q)
                    FR_OPC: begin
                        opc_q <= byte_in;
                        have_opc_q <= 1'b1;
                        // Power-down lets only the release through
                        if (!pw_ok && (byte_in != OPC_POWER_UP || pw_q == PW_WAKE)) begin
                            fr_q <= FR_SKIP; // RULE18
                        end else begin
                            case (byte_in)
                                OPC_READ_STATUS, OPC_READ_CONFIG: begin
                                    // No busy check here: polling works mid-write
                                    osel_q <= (byte_in == OPC_READ_CONFIG) ? 2'd1 : 2'd0; // RULE1 RULE2
                                    fr_q <= quad ? FR_DUMMY : FR_OUT; // RULE4
                                end
                                OPC_WRITE_REGS: fr_q <= FR_DATA; // RULE7
                                OPC_POWER_UP: begin
                                    osel_q <= 2'd2;
                                    fr_q <= FR_DUMMY; // RULE21
                                end
                                default: fr_q <= FR_SKIP; // No payload
                            endcase
                        end
                    end
                    FR_DUMMY: begin
                        // One dummy byte for reads, three for the ID
                        dcnt_q <= dcnt_q + 2'd1;
                        if (dcnt_q == ((osel_q == 2'd2) ? 2'd2 : 2'd0)) begin
                            fr_q <= FR_OUT; // RULE4 RULE21
                        end
                    end
                    FR_DATA: begin
                        // Bytes past the second are dropped
                        if (nbyte_q == 2'd0) begin
                            sr_new_q <= byte_in; // RULE8
                        end
                        if (nbyte_q == 2'd1) begin
                            cr_new_q <= byte_in; // RULE8
                        end
                        if (nbyte_q != 2'd2) begin
                            nbyte_q <= nbyte_q + 2'd1; // RULE7
                        end
                    end
                    default: fr_q <= FR_SKIP;
                endcase
            end
        end
    end

    // ==========================================
    // Output driver
    // Changes on falling edges; byte reloads from live value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sio_out <= 4'h0;
            sio_oe <= 4'h0;
            ob_q <= 8'h00;
            ocnt_q <= 3'd0;
        end else if (ce_rise || ce_fall) begin
            sio_oe <= 4'h0; // RULE6
            sio_out <= 4'h0;
            ocnt_q <= 3'd0;
        end else if (sck_fall && fr_q == FR_OUT) begin
            if (quad) begin
                sio_out <= (ocnt_q == 3'd0) ? live[7:4] : ob_q[7:4]; // RULE5
                ob_q <= {((ocnt_q == 3'd0) ? live[3:0] : ob_q[3:0]), 4'h0};
                sio_oe <= 4'hF;
                ocnt_q <= (ocnt_q == 3'd1) ? 3'd0 : 3'd1; // RULE6
            end else begin
                sio_out <= {2'b00, ((ocnt_q == 3'd0) ? live[7] : ob_q[7]), 1'b0}; // RULE5
                ob_q <= {((ocnt_q == 3'd0) ? live[6:0] : ob_q[6:0]), 1'b0};
                sio_oe <= 4'b0010;
                ocnt_q <= ocnt_q + 3'd1; // RULE6
            end
        end
    end

    // ==========================================
    // Latch, protect bits and config
    // Acted on at chip enable rise, only in full power
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wel_q <= 1'b0;
            bp_q <= BP_RST;
            cr_q <= CR_RST; // RULE15
        end else if (commit && pw_ok) begin
            case (opc_q)
                OPC_SET_LATCH: wel_q <= 1'b1; // RULE9
                OPC_CLR_LATCH: if (!busy) wel_q <= 1'b0; // RULE11 RULE12
                OPC_WRITE_REGS: begin
                    if (wel_q && !busy && nbyte_q != 2'd0) begin // RULE23
                        if (!lock) bp_q <= sr_new_q[SR_BP_LO+3:SR_BP_LO]; // RULE8 RULE13
                        if (nbyte_q == 2'd2) begin
                            cr_q <= (cr_q & ~CR_WR_MASK) | (cr_new_q & CR_WR_MASK); // RULE8
                        end
                        wel_q <= 1'b0;
                    end
                end
                OPC_LOCKDOWN: begin
                    if (wel_q && !busy) begin // RULE23
                        cr_q[CR_VLP] <= 1'b1; // RULE14
                        wel_q <= 1'b0;
                    end
                end
                default: wel_q <= wel_q;
            endcase
        end
    end

    // ==========================================
    // Power state
    // Timers are trimmed by synchroniser delay to meet pin budget
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pw_q <= PW_ON;
            tmr_q <= '0;
            low_power <= 1'b0;
        end else begin
            case (pw_q)
                PW_ON: begin
                    if (commit && opc_q == OPC_POWER_DOWN && !busy) begin // RULE16 RULE17
                        pw_q <= PW_ENTER;
                        tmr_q <= '0;
                    end
                end
                PW_ENTER, PW_DOWN: begin
                    tmr_q <= tmr_q + 1'b1;
                    if (commit && opc_q == OPC_POWER_UP) begin
                        pw_q <= PW_WAKE; // RULE20
                        tmr_q <= '0;
                        low_power <= 1'b0;
                    end else if (pw_q == PW_ENTER && tmr_q == TMR_W'(PD_ENTRY_CYC - 1)) begin
                        pw_q <= PW_DOWN; // RULE19
                        low_power <= 1'b1;
                    end
                end
                PW_WAKE: begin
                    tmr_q <= tmr_q + 1'b1;
                    if (tmr_q == TMR_W'(STANDBY_CYC - 1)) begin
                        pw_q <= PW_ON; // RULE20
                    end
                end
                default: pw_q <= PW_ON;
            endcase
        end
    end

    // ==========================================
    // APB slave
    // Zero wait: ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
            ctrl_q <= 2'b00;
        end else begin
            pready <= psel & ~penable;
            if (psel && !penable) begin
                pslverr <= (paddr != ADDR_CTRL) && (paddr != ADDR_STATE);
                if (paddr == ADDR_CTRL && !pwrite) begin
                    prdata <= {30'h0, ctrl_q};
                end else if (paddr == ADDR_STATE && !pwrite) begin
                    prdata <= {14'h0, pw_q == PW_WAKE, low_power, cr_q, sr_live};
                end else begin
                    prdata <= 32'h0; // Unmapped or write
                end
            end
            if (psel && penable && pready && pwrite && paddr == ADDR_CTRL) begin
                ctrl_q <= pwdata[1:0];
            end
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_latch_set: assert property (commit && pw_ok && opc_q == OPC_SET_LATCH |=> wel_q) // RULE9
        else $error("latch not set");
    chk_clear_busy: assert property ( // RULE12
        commit && opc_q == OPC_CLR_LATCH && busy |=> wel_q == $past(wel_q))
        else $error("latch cleared while busy");
    chk_clear_latch: assert property ( // RULE11
        commit && pw_ok && opc_q == OPC_CLR_LATCH && !busy |=> !wel_q)
        else $error("latch not cleared");
    chk_bp_frozen: assert property (lock && commit |=> bp_q == $past(bp_q)) // RULE13
        else $error("protect bits changed under lock");
    chk_lock_set: assert property ( // RULE14
        commit && pw_ok && opc_q == OPC_LOCKDOWN && wel_q && !busy |=> lock)
        else $error("lock flag not set");
    chk_lock_sticky: assert property (lock |=> lock) // RULE15
        else $error("lock cleared without reset");
    chk_write_gate: assert property ( // RULE23
        commit && opc_q == OPC_WRITE_REGS && !wel_q |=> $stable(cr_q) && $stable(bp_q))
        else $error("write without latch");
    chk_pd_busy: assert property ( // RULE17
        pw_ok && commit && opc_q == OPC_POWER_DOWN && busy |=> pw_q == PW_ON)
        else $error("power-down entered while busy");
    chk_pd_entry: assert property ($rose(pw_q == PW_ENTER) |-> ##[1:750] low_power) // RULE19
        else $error("power-down entry too slow");
    chk_pd_ignore: assert property ( // RULE18
        pw_q == PW_DOWN && commit && opc_q != OPC_POWER_UP |=> pw_q == PW_DOWN && $stable(wel_q))
        else $error("command obeyed in power-down");
    logic [TMR_W-1:0] wake_cyc_q; // Cycles spent waking; too long for a delay range
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) wake_cyc_q <= '0;
        else wake_cyc_q <= (pw_q == PW_WAKE) ? wake_cyc_q + 1'b1 : '0;
    end
    chk_wake_time: assert property ( // RULE20
        pw_q == PW_WAKE |-> wake_cyc_q < TMR_W'(STANDBY_CYC))
        else $error("standby not reached in time");
    chk_out_stop: assert property (ce_rise |=> sio_oe == 4'h0 ##1 fr_q == FR_IDLE) // RULE6
        else $error("output past chip enable");
    chk_single_read: assert property ( // RULE4
        fr_q == FR_OPC && sck_rise && last && !quad && byte_in == OPC_READ_STATUS
        && pw_ok && !ce_rise |=> fr_q == FR_OUT)
        else $error("single read not immediate");
    cov_status_poll: cover property (fr_q == FR_OUT && osel_q == 2'd0 && busy && sck_fall);
    cov_id_read: cover property (fr_q == FR_OUT && osel_q == 2'd2 && sck_fall);
    cov_power_cycle: cover property ($fell(low_power) && pw_q == PW_WAKE);
    cov_lockdown: cover property ($rose(lock));
endmodule : fsp_core

// *** dv/fsp_host_model.sv ***
`timescale 1ns/10ps
// ==========================================
// Host side of the serial link, behavioural
module fsp_host_model (
    input wire logic [3:0] sio_out, // Device data
    input wire logic [3:0] sio_oe, // Device enables
    output logic ce_n, // Chip enable, low
    output logic sck, // Serial clock, idle low
    output logic [3:0] sio_in // Resolved pins
);
    logic [3:0] hd; // Host data
    logic [3:0] hoe; // Host enables
    logic [3:0] flt = 4'hA; // Undriven pin pattern
    logic [15:0] rd; // Last two bytes seen
    logic quad; // Four-line transfer
    event got; // Read-back ready
    initial begin
        ce_n = 1'b1;
        sck = 1'b0;
        hoe = 4'h0;
        hd = 4'h0;
    end
    // Floating pins toggle, so stale data never matches by luck
    always #16 flt = ~flt;
    // Wire level from both parties
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            sio_in[i] = hoe[i] ? hd[i] : (sio_oe[i] ? sio_out[i] : flt[i]);
        end
    end
    // One clock: drive, rise and sample, fall
    task cyc(input logic [3:0] d, input logic [3:0] oe);
        hd = d;
        hoe = oe;
        #32 sck = 1'b1;
        rd = quad ? {rd[11:0], sio_in} : {rd[14:0], sio_in[1]};
        #32 sck = 1'b0;
    endtask : cyc
    // Frame: opcode, data bytes, dummies, read bytes
    task xfer(input logic q, input logic [7:0] op, input int nw, input logic [15:0] wd,
              input int nd, input int nr);
        logic [23:0] sh;
        int w;
        quad = q;
        w = q ? 4 : 1;
        sh = {op, wd};
        ce_n = 1'b0;
        for (int k = 0; k < (8 + 8 * nw) / w; k++) begin
            cyc(q ? sh[23:20] : {3'h0, sh[23]}, q ? 4'hF : 4'h1);
            sh = sh << w;
        end
        // Host lets go of the pins for dummies and read-back
        for (int k = 0; k < 8 * (nd + nr) / w; k++) begin
            cyc(4'h0, 4'h0);
        end
        #32 ce_n = 1'b1;
        hoe = 4'h0;
        #128;
        if (nr > 0) begin
            -> got;
        end
    endtask : xfer
endmodule : fsp_host_model

// *** dv/flash_status_power_commands_bench.sv ***
`timescale 1ns/10ps
// ==========================================
// Bench: APB master, link host, queued checks
module flash_status_power_commands_bench;
    import fsp_pkg::*;
    localparam logic [7:0] ID_VAL = 8'h3C; // Arbitrary identifier value
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr; // Bus
    logic [7:0] paddr; // Bus address
    logic [31:0] pwdata, prdata; // Bus data
    logic ce_n, sck, low_power; // Link and mode
    logic [3:0] sio_in, sio_out, sio_oe; // Data pins
    int mismatches, samples_checked, seed, n;
    logic [32:0] qa[$]; // Expected bus reads
    logic [15:0] ql[$]; // Expected link reads
    logic [3:0] bp; // Expected protect bits
    logic [7:0] cfg; // Expected config
    logic [15:0] wd; // Random write data
    logic wel, busy, q; // Expected latch, busy, quad
    fsp_core #(.DEV_ID(ID_VAL)) fsp_core_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ce_n(ce_n), .sck(sck),
        .sio_in(sio_in), .sio_out(sio_out), .sio_oe(sio_oe), .low_power(low_power));
    fsp_host_model fsp_host_model_inst (.sio_out(sio_out), .sio_oe(sio_oe), .ce_n(ce_n),
        .sck(sck), .sio_in(sio_in));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // Expected status byte and live view
    function automatic logic [7:0] sr();
        return {2'h0, bp, wel, busy};
    endfunction : sr
    function automatic logic [31:0] st(input logic lp);
        return {15'h0, lp, cfg, sr()};
    endfunction : st
    task chk(input string nm, input logic [32:0] e, input logic [32:0] s);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task summarize();
        if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize
    // One APB transfer, held until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) mismatches++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rd(input logic [7:0] a, input logic [32:0] e);
        qa.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task cmd(input logic [7:0] op, input int nw, input int nd, input int nr,
             input logic [15:0] e);
        if (nr > 0) ql.push_back(e);
        // Pins move 1 ns off the clock edge, then the bench realigns
        @(posedge pclk);
        #1;
        fsp_host_model_inst.xfer(q, op, nw, wd, nd, nr);
        @(posedge pclk);
    endtask : cmd
    task ctrl();
        apb(1'b1, ADDR_CTRL, {30'h0, busy, q});
    endtask : ctrl
    task latch();
        cmd(OPC_SET_LATCH, 0, 0, 0, 16'h0);
        wel = 1'b1;
    endtask : latch
    // Register write; model follows latch, busy and lock
    task wr_regs(input int nw);
        wd = 16'($random(seed));
        cmd(OPC_WRITE_REGS, nw, 0, 0, 16'h0);
        if (wel && !busy) begin
            if (!cfg[CR_VLP]) bp = wd[13:10];
            if (nw == 2) cfg = (wd[7:0] & CR_WR_MASK) | (cfg & ~CR_WR_MASK);
            wel = 1'b0;
        end
    endtask : wr_regs
    task rst();
        presetn <= 1'b0;
        {bp, cfg, wel, busy, q} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask : rst
    // ==========================================
    // Result watchers pop the oldest expectation
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            chk("apb_read", qa.pop_front(), {pslverr, prdata});
        end
    end
    initial forever begin
        @(fsp_host_model_inst.got);
        chk("link_read", {17'h0, ql.pop_front()}, {17'h0, fsp_host_model_inst.rd});
    end
    // Watchdog, well past the expected run
    initial begin
        #200000;
        mismatches++;
        summarize();
    end
    // ==========================================
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {mismatches, samples_checked} = '0;
        seed = 32'h11BDD9D0;
        wd = 16'h0;
        rst();
        rd(ADDR_STATE, {1'b0, st(1'b0)});
        rd(8'h08, {1'b1, 32'h0});
        apb(1'b1, ADDR_STATE, 32'hFFFFFFFF);
        rd(ADDR_STATE, {1'b0, st(1'b0)});
        // Single, then quad
        for (int m = 0; m < 2; m++) begin
            q = m[0];
            ctrl();
            wr_regs(2);
            latch();
            cmd(OPC_READ_STATUS, 0, q, 2, {sr(), sr()});
            wr_regs(2);
            cmd(OPC_READ_CONFIG, 0, q, 2, {cfg, cfg});
            latch();
            wr_regs(1);
            latch();
            cmd(OPC_CLR_LATCH, 0, 0, 0, 16'h0);
            wel = 1'b0;
            rd(ADDR_STATE, {1'b0, st(1'b0)});
        end
        // Internal write running
        latch();
        busy = 1'b1;
        ctrl();
        cmd(OPC_CLR_LATCH, 0, 0, 0, 16'h0);
        cmd(OPC_POWER_DOWN, 0, 0, 0, 16'h0);
        cmd(OPC_READ_STATUS, 0, q, 2, {sr(), sr()});
        rd(ADDR_STATE, {1'b0, st(1'b0)});
        busy = 1'b0;
        ctrl();
        cmd(OPC_LOCKDOWN, 0, 0, 0, 16'h0);
        cfg[CR_VLP] = 1'b1;
        wel = 1'b0;
        latch();
        wr_regs(2);
        rd(ADDR_STATE, {1'b0, st(1'b0)});
        // Power-down; host returns 32 cycles after the pin, one more to see it
        cmd(OPC_POWER_DOWN, 0, 0, 0, 16'h0);
        n = 0;
        while (low_power !== 1'b1 && n < 1000) begin
            @(posedge pclk);
            n++;
        end
        chk("pd_entry", 33'h1, {32'h0, low_power === 1'b1 && n + 32 <= 751});
        cmd(OPC_SET_LATCH, 0, 0, 0, 16'h0);
        rd(ADDR_STATE, {1'b0, st(1'b1)});
        cmd(OPC_POWER_UP, 0, 3, 2, {ID_VAL, ID_VAL});
        // Next frame starts no later than 10 us after the pin rose
        repeat (2466) @(posedge pclk);
        latch();
        rd(ADDR_STATE, {1'b0, st(1'b0)});
        // Reset in mid-run drops the lock
        rst();
        rd(ADDR_STATE, {1'b0, st(1'b0)});
        latch();
        wr_regs(1);
        rd(ADDR_STATE, {1'b0, st(1'b0)});
        summarize();
    end
endmodule : flash_status_power_commands_bench
